/* File: rtl/board_interrupt_aggregator.v */
`timescale 1ns/10ps
`default_nettype none

`include "board_irq_regs.vh"

// Overview of operation
// - Drive six level-sensitive processor interrupt lines
// - Line 3 from mask register one bits 3:0
// - Line 2 from mask register one bits 5:4
// - Line 1 from mask register two bits 2:0
// - Line 0 from registers three and four
// - Mask one disables source, zero enables
// - Masks are write only, never read back
// - Reads return live source state, unmasked
// - Line 0 storage/network/mezzanine/southbridge/levels 1-3
// - Line 2 location monitor and heartbeat
// - Line 3 timers, reset, level 7, interface
// - Line 4 southbridge NMI, line 5 bridge
// - Nineteen sources, each programmable to seven levels
// - Fixed ranking breaks ties between pending requests
// - Reason read launches a local acknowledge cycle
// - Acknowledge returns winner vector and level
// - Winner is highest level enabled active request
// - Level sits in bits 10:8 of result
// - Result returned as reason register read data
// - Backplane requests reach masks via encoded level
module board_interrupt_aggregator #(
  parameter NUM_SRC = 19,
  parameter HB_CNT_W = 20,
  parameter [HB_CNT_W-1:0] HEARTBEAT_CYCLES =
    `HB_CYCLES
)(
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [31:0] wrData,
  input wire wrEn,
  input wire rdEn,
  output reg [31:0] rdData,
  input wire intervalTimerReq,
  input wire backplaneResetReq,
  input wire periodicTimerReq,
  input wire locMonitorReq,
  input wire mezzIntaReq,
  input wire storageReq,
  input wire networkReq,
  input wire [3:0] mezzOtherReq,
  input wire southbridgeReq,
  input wire southNmiReq,
  input wire hostBridgeReq,
  input wire [NUM_SRC-1:0] prioSrcReq,
  output reg [5:0] cpuIrq,
  output reg [2:0] encodedPriorityLines,
  output reg localIack
);

  // ******************************************************************
  // Functions
  // ******************************************************************
  // One decoded level per call keeps the bit map easy to audit; levels 4 and 5 share a status bit.
  function lvlHit;
    input [2:0] lvl;
    input [2:0] k;
    begin
      lvlHit = (lvl == k);
    end
  endfunction

  function [7:0] regWord;
    input [31:0] d;
    begin
      regWord = d[7:0];
    end
  endfunction

  // ******************************************************************
  // Input synchronisers
  // ******************************************************************
  localparam IN_W = 14 + NUM_SRC;

  wire [IN_W-1:0] rawIn;
  reg [IN_W-1:0] sync1_ff;
  reg [IN_W-1:0] sync2_ff;

  assign rawIn = {prioSrcReq, hostBridgeReq, southNmiReq,
    southbridgeReq, mezzOtherReq, networkReq, storageReq,
    mezzIntaReq, locMonitorReq, periodicTimerReq,
    backplaneResetReq, intervalTimerReq};

  // Every source is asynchronous to the board clock, so each one pays
  // two cycles of latency here before any decode may look at it.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_ff <= {IN_W{1'b0}};
      sync2_ff <= {IN_W{1'b0}};
    end
    else
    begin
      sync1_ff <= rawIn;
      sync2_ff <= sync1_ff;
    end
  end

  wire sIntervalTimer = sync2_ff[0];
  wire sBackplaneReset = sync2_ff[1];
  wire sPeriodicTimer = sync2_ff[2];
  wire sLocMonitor = sync2_ff[3];
  wire sMezzInta = sync2_ff[4];
  wire sStorage = sync2_ff[5];
  wire sNetwork = sync2_ff[6];
  wire [3:0] sMezzOther = sync2_ff[10:7];
  wire sSouthbridge = sync2_ff[11];
  wire sSouthNmi = sync2_ff[12];
  wire sHostBridge = sync2_ff[13];
  wire [NUM_SRC-1:0] sPrioSrc = sync2_ff[IN_W-1:14];

  // ******************************************************************
  // Register decode
  // ******************************************************************
  wire wrMask1 = wrEn && (addr == `OFS_MASK_ONE);
  wire wrMask2 = wrEn && (addr == `OFS_MASK_TWO);
  wire wrMask3 = wrEn && (addr == `OFS_MASK_THREE);
  wire wrMask4 = wrEn && (addr == `OFS_MASK_FOUR);
  wire wrVecBase = wrEn && (addr == `OFS_VECTOR_BASE);
  // The clear needs bit 0 set, so a stray zero write to this location
  // leaves a pending heartbeat request alone.
  wire wrHbClear = wrEn && (addr == `OFS_HB_CLEAR) &&
    wrData[`HB_CLEAR_BIT];
  wire rdReason = rdEn && (addr == `OFS_REASON);
  wire prioCtrlHit = (addr >= `OFS_PRIO_CTRL_BASE) &&
    (addr <= `OFS_PRIO_CTRL_LAST) && (addr[1:0] == 2'b00);
  // Each control word has its own 32-bit slot, so the source index is
  // the distance from the first slot divided by four.
  wire [7:0] prioOfs = addr - `OFS_PRIO_CTRL_BASE;
  wire [5:0] prioIdx = prioOfs[7:2];

  // ******************************************************************
  // Mask and control registers
  // ******************************************************************
  reg [7:0] mask1_ff;
  reg [7:0] mask2_ff;
  reg [7:0] mask3_ff;
  reg [7:0] mask4_ff;
  reg [7:0] vecBase_ff;
  reg [2:0] prioLevel_ff [0:NUM_SRC-1];
  integer i;

  // A one written to a mask bit blocks the source, zero opens it.
  // Writes to unmapped addresses match no decode and change nothing.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mask1_ff <= `MASK_RESET;
      mask2_ff <= `MASK_RESET;
      mask3_ff <= `MASK_RESET;
      mask4_ff <= `MASK_RESET;
      vecBase_ff <= `VECTOR_BASE_RESET;
    end
    else
    begin
      if (wrMask1)
        mask1_ff <= regWord(wrData);
      if (wrMask2)
        mask2_ff <= regWord(wrData);
      if (wrMask3)
        mask3_ff <= regWord(wrData);
      if (wrMask4)
        mask4_ff <= regWord(wrData);
      if (wrVecBase)
        vecBase_ff <= regWord(wrData);
    end
  end

  // Level zero parks a source; levels one to seven are live.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (i = 0; i < NUM_SRC; i = i + 1)
        prioLevel_ff[i] <= 3'h0;
    end
    else if (wrEn && prioCtrlHit)
    begin
      for (i = 0; i < NUM_SRC; i = i + 1)
        if (prioIdx == i[5:0])
          prioLevel_ff[i] <= wrData[2:0];
    end
  end

  // ******************************************************************
  // Priority unit
  // ******************************************************************
  reg [2:0] winLevel;
  reg [4:0] winIdx;
  reg winValid;
  integer j;

  // Scanning upward with >= lets the higher rank take a tie, so the
  // ranking stays fixed and cannot be reprogrammed.
  // The compare chain grows with NUM_SRC; a much larger source count
  // would need this scan split over two cycles.
  always @*
  begin
    winLevel = 3'h0;
    winIdx = 5'h00;
    winValid = 1'b0;
    for (j = 0; j < NUM_SRC; j = j + 1)
    begin
      if (sPrioSrc[j] && (prioLevel_ff[j] != 3'h0) &&
          (prioLevel_ff[j] >= winLevel))
      begin
        winLevel = prioLevel_ff[j];
        winIdx = j[4:0];
        winValid = 1'b1;
      end
    end
  end

  // Bits 4:0 of the vector name the winning source and only bits 7:5
  // of the base reach it; lower base bits are only stored and read back.
  wire [7:0] winVector = {vecBase_ff[7:5], winIdx};
  reg [31:0] reasonWord;

  // The level gets a field of its own above the vector, so software
  // reads both from one word without a second access.
  always @*
  begin
    reasonWord = {24'h000000, winVector};
    reasonWord[`LEVEL_MSB:`LEVEL_LSB] = winLevel;
  end

  // Level and acknowledge leave through flops, so the far side sees
  // clean levels and a one-cycle strobe beside the reason data.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      encodedPriorityLines <= 3'h0;
      localIack <= 1'b0;
    end
    else
    begin
      encodedPriorityLines <= winValid ? winLevel : 3'h0;
      localIack <= rdReason;
    end
  end

  // ******************************************************************
  // Heartbeat timer
  // ******************************************************************
  reg [HB_CNT_W-1:0] hbCnt_ff;
  reg hbReq_ff;
  wire hbTick = (hbCnt_ff == HEARTBEAT_CYCLES - 1'b1);

  // The tick period is a parameter so a test can shorten the one
  // millisecond interval to a few thousand cycles.
  // A tick landing on the clear write keeps the request pending.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hbCnt_ff <= {HB_CNT_W{1'b0}};
      hbReq_ff <= 1'b0;
    end
    else
    begin
      hbCnt_ff <= hbTick ? {HB_CNT_W{1'b0}} : hbCnt_ff + 1'b1;
      if (hbTick)
        hbReq_ff <= 1'b1;
      else if (wrHbClear)
        hbReq_ff <= 1'b0;
    end
  end

  // ******************************************************************
  // Source status words
  // ******************************************************************
  wire [2:0] lvl = encodedPriorityLines;
  wire [7:0] stat1;
  wire [7:0] stat2;
  wire [7:0] stat3;
  wire [7:0] stat4;

  // Backplane requests and interface events arrive only as an encoded
  // level, so a status bit shows whichever level is being driven.
  // Bits above each register's last source always read as zero.
  assign stat1 = {2'b00, hbReq_ff, sLocMonitor,
    sPeriodicTimer, lvlHit(lvl, 3'h7),
    sBackplaneReset, sIntervalTimer};
  assign stat2 = {5'h00, lvlHit(lvl, 3'h6),
    lvlHit(lvl, 3'h5) | lvlHit(lvl, 3'h4), sMezzInta};
  assign stat3 = {lvlHit(lvl, 3'h1), sSouthbridge,
    sMezzOther, sNetwork, sStorage};
  assign stat4 = {6'h00, lvlHit(lvl, 3'h3),
    lvlHit(lvl, 3'h2)};

  // ******************************************************************
  // Processor interrupt lines
  // ******************************************************************
  wire [7:0] live1 = stat1 & ~mask1_ff;
  wire [7:0] live2 = stat2 & ~mask2_ff;
  wire [7:0] live3 = stat3 & ~mask3_ff;
  wire [7:0] live4 = stat4 & ~mask4_ff;

  // Lines come from flops so a glitch in the status decode never
  // reaches the processor, at the price of one more cycle of latency.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      cpuIrq <= 6'h00;
    else
    begin
      cpuIrq[0] <= |live3 | (|live4[1:0]);
      cpuIrq[1] <= |live2[2:0];
      cpuIrq[2] <= |live1[5:4];
      cpuIrq[3] <= |live1[3:0];
      cpuIrq[4] <= sSouthNmi;
      cpuIrq[5] <= sHostBridge;
    end
  end

  // ******************************************************************
  // Read path
  // ******************************************************************
  reg [31:0] nxt_rdData;
  integer r;

  // Mask locations answer with the raw sources; the stored masks have
  // no read path at all.
  // Unmapped addresses read as zero rather than a stale value.
  always @*
  begin
    nxt_rdData = 32'h00000000;
    if (rdEn)
    begin
      case (addr)
        `OFS_MASK_ONE: nxt_rdData = {24'h000000, stat1};
        `OFS_MASK_TWO: nxt_rdData = {24'h000000, stat2};
        `OFS_MASK_THREE: nxt_rdData = {24'h000000, stat3};
        `OFS_MASK_FOUR: nxt_rdData = {24'h000000, stat4};
        `OFS_REASON: nxt_rdData = reasonWord;
        `OFS_VECTOR_BASE: nxt_rdData = {24'h000000, vecBase_ff};
        `OFS_PRIO_STATUS:
          nxt_rdData = {23'h000000, winValid, 3'h0, winIdx};
        default:
        begin
          if (prioCtrlHit)
          begin
            for (r = 0; r < NUM_SRC; r = r + 1)
              if (prioIdx == r[5:0])
                nxt_rdData = {29'h00000000, prioLevel_ff[r]};
          end
        end
      endcase
    end
  end

  // The reason word is frozen at the acknowledge edge, so a source that
  // drops afterwards cannot change the vector already handed out.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      rdData <= 32'h00000000;
    else
      rdData <= nxt_rdData;
  end

endmodule // board_interrupt_aggregator

`default_nettype wire

/* File: rtl/board_irq_regs.vh */
`ifndef BOARD_IRQ_REGS_VH
`define BOARD_IRQ_REGS_VH

// ********************************************************************
// Register offsets (byte addresses on the 8-bit register port)
// ********************************************************************
`define OFS_MASK_ONE 8'h00
`define OFS_MASK_TWO 8'h04
`define OFS_MASK_THREE 8'h08
`define OFS_MASK_FOUR 8'h0C
`define OFS_REASON 8'h10
`define OFS_VECTOR_BASE 8'h14
`define OFS_HB_CLEAR 8'h18
`define OFS_PRIO_STATUS 8'h1C
`define OFS_PRIO_CTRL_BASE 8'h40
`define OFS_PRIO_CTRL_LAST 8'h88

// ********************************************************************
// Reset values and field positions
// ********************************************************************
`define MASK_RESET 8'hFF
`define VECTOR_BASE_RESET 8'h00
`define LEVEL_MSB 10
`define LEVEL_LSB 8
`define HB_CLEAR_BIT 0

// ********************************************************************
// Timing
// ********************************************************************
`define HB_TIME_NS 1000000
`define CLK_PERIOD_NS 4
`define HB_CYCLES 20'h3D090

`endif

/* File: test/host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Processor side of the register port
// ****
module host_model (
  input wire logic clk,
  input wire logic [31:0] rdData,
  output logic [7:0] addr = 8'h00,
  output logic [31:0] wrData = 32'h0,
  output logic wrEn = 1'b0,
  output logic rdEn = 1'b0
);
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    d = rdData;
  endtask
endmodule // host_model
`default_nettype wire

/* File: test/irq_checker.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Port properties of the interrupt aggregator
// ****
module irq_checker #(
  parameter NUM_SRC = 19
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [31:0] rdData,
  input wire logic southNmiReq,
  input wire logic hostBridgeReq,
  input wire logic [NUM_SRC-1:0] prioSrcReq,
  input wire logic [5:0] cpuIrq,
  input wire logic [2:0] encodedPriorityLines,
  input wire logic localIack
);
  logic maskWritten_ff;
  // Until software has written any mask register, lines 3:0 may not rise.
  always_ff @(posedge clk or posedge rst)
    if (rst)
      maskWritten_ff <= 1'b0;
    else if (wrEn && addr < 8'h10)
      maskWritten_ff <= 1'b1;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_IACK_LAUNCH: assert property (
    rdEn && addr == 8'h10 |=> localIack)
    else $error("no acknowledge after a reason read");
  AST_IACK_CAUSE: assert property (
    localIack |-> $past(rdEn) && $past(addr) == 8'h10)
    else $error("acknowledge without a reason read");
  AST_RD_IDLE: assert property (
    !$past(rdEn) |-> rdData == 32'h0)
    else $error("read data outside its cycle");
  AST_REASON_FORM: assert property (
    localIack |-> rdData[31:11] == 21'h0 &&
      rdData[10:8] == encodedPriorityLines)
    else $error("level field of the reason value is wrong");
  AST_NMI_LINE: assert property (
    southNmiReq [*4] |-> cpuIrq[4])
    else $error("line 4 does not follow its source");
  AST_BRIDGE_QUIET: assert property (
    (!hostBridgeReq) [*4] |-> !cpuIrq[5])
    else $error("line 5 high without its source");
  AST_MASK_RESET: assert property (
    !maskWritten_ff |-> cpuIrq[3:0] == 4'h0)
    else $error("masked line active after reset");
  AST_NO_REQ_NO_LEVEL: assert property (
    (prioSrcReq == '0) [*5] |-> encodedPriorityLines == 3'h0)
    else $error("level reported with no request");
endmodule // irq_checker
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Self-checking bench
// ****
module testbench;
  localparam int HB = 3000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] src = 14'h0;
  logic [18:0] prio = 19'h0;
  logic [31:0] rdData, wrData, got;
  logic [7:0] addr, vb, msk [4], st [4];
  logic [5:0] cpuIrq, ei;
  logic [2:0] lv [19], bl;
  logic wrEn, rdEn;
  integer err_total = 0, compares = 0, seed = 32'h686fc456, k, i, best;
  host_model host_u (.clk(clk), .rdData(rdData), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn));
  board_interrupt_aggregator #(.HEARTBEAT_CYCLES(20'(HB))) dut_u (
    .clk(clk), .rst(rst), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .intervalTimerReq(src[0]), .backplaneResetReq(src[1]),
    .periodicTimerReq(src[2]), .locMonitorReq(src[3]),
    .mezzIntaReq(src[4]), .storageReq(src[5]), .networkReq(src[6]),
    .mezzOtherReq(src[10:7]), .southbridgeReq(src[11]),
    .southNmiReq(src[12]), .hostBridgeReq(src[13]), .prioSrcReq(prio),
    .cpuIrq(cpuIrq), .encodedPriorityLines(), .localIack());
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
    forever #2 clk = ~clk;
  initial
  begin
    #40000;
    err_total++;
    summarize;
  end
  initial
  begin
    vb = 8'h00;
    for (i = 0; i < 19; i++)
      lv[i] = 3'h0;
    for (i = 0; i < 4; i++)
      msk[i] = 8'hFF;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // Pass 0 keeps the reset masks with all 14 direct sources raised and no priority request.
    for (k = 0; k < 24; k++)
    begin
      if (k > 0)
      begin
        prio <= 19'($random(seed));
        src <= 14'($random(seed));
        vb = 8'($random(seed));
        host_u.wr(8'h14, {24'h0, vb});
        for (i = 0; i < 19; i++)
        begin
          lv[i] = 3'($random(seed));
          host_u.wr(8'h40 + 8'(4 * i), {29'h0, lv[i]});
        end
        for (i = 0; i < 4; i++)
        begin
          msk[i] = 8'($random(seed));
          host_u.wr(8'(4 * i), {24'h0, msk[i]});
        end
      end
      else
        src <= 14'h3FFF;
      repeat (8) @(posedge clk);
      #1;
      bl = 3'h0;
      best = 0;
      for (i = 0; i < 19; i++)
        if (prio[i] && lv[i] != 3'h0 && lv[i] >= bl)
        begin
          bl = lv[i];
          best = i;
        end
      st[0] = {2'b0, src[3], src[2], bl == 3'h7, src[1:0]};
      st[1] = {5'h0, bl == 3'h6, bl == 3'h4 || bl == 3'h5, src[4]};
      st[2] = {bl == 3'h1, src[11:5]};
      st[3] = {6'h0, bl == 3'h3, bl == 3'h2};
      ei = {src[13], src[12], |(st[0][3:0] & ~msk[0][3:0]),
        |(st[0][5:4] & ~msk[0][5:4]), |(st[1][2:0] & ~msk[1][2:0]),
        |(st[2] & ~msk[2]) | |(st[3][1:0] & ~msk[3][1:0])};
      chk({26'h0, cpuIrq}, {26'h0, ei});
      for (i = 0; i < 4; i++)
      begin
        host_u.rd(8'(4 * i), got);
        chk(got, {24'h0, st[i]});
      end
      host_u.rd(8'h14, got);
      chk(got, {24'h0, vb});
      host_u.rd(8'h1C, got);
      chk(got, {23'h0, bl != 3'h0, 3'h0, 5'(best)});
      host_u.rd(8'h40 + 8'(4 * (k % 19)), got);
      chk(got, {29'h0, lv[k % 19]});
      if (bl != 3'h0)
      begin
        host_u.rd(8'h10, got);
        chk(got, {21'h0, bl, vb[7:5], 5'(best)});
      end
      else
      begin
        host_u.rd(8'h30, got);
        chk(got, 32'h0);
      end
      $display("test %0d done", k);
    end
    // The loop ends well before the first tick; only bit 5 is opened.
    host_u.wr(8'h00, 32'h000000DF);
    repeat (HB) @(posedge clk);
    #1;
    chk({31'h0, cpuIrq[2]}, 32'h1);
    host_u.rd(8'h00, got);
    chk({31'h0, got[5]}, 32'h1);
    host_u.wr(8'h18, 32'h00000001);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, cpuIrq[2]}, 32'h0);
    host_u.rd(8'h00, got);
    chk({31'h0, got[5]}, 32'h0);
    $display("test heartbeat done");
    summarize;
  end
endmodule // testbench
bind board_interrupt_aggregator irq_checker #(.NUM_SRC(NUM_SRC)) chk_u (
  .clk, .rst, .addr, .wrEn, .rdEn, .rdData, .southNmiReq, .hostBridgeReq,
  .prioSrcReq, .cpuIrq, .encodedPriorityLines, .localIack);
`default_nettype wire
